// ===== inc/lpw_pkg.sv
// package for the low power wake-up controller: register map, fields, timing constants
// assumes one 250 MHz core clock and classic wishbone register access
package lpw_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CLKMD  = 4'h0;  // clock mode
  localparam logic [3:0] ADDR_WAKEEN = 4'h4;  // per-pin wake enable
  localparam logic [3:0] ADDR_AUX    = 4'h8;  // auxiliary control
  localparam logic [3:0] ADDR_STAT   = 4'hc;  // status, read only
  // clock mode fields
  localparam int CLK_FAST_EN = 4;
  localparam int CLK_SLOW_EN = 2;
  localparam int CLK_WDT_EN  = 1;
  localparam logic [7:0] CLKMD_RST = 8'hf6;
  // aux fields
  localparam int AUX_FAST_WAKE = 0;
  localparam logic [7:0] AUX_RST    = 8'h00;
  localparam logic [7:0] WAKEEN_RST = 8'h00;
  // wake counts in slow oscillator periods
  localparam logic [11:0] WAKE_NORMAL_CNT = 12'h800;  // 2048
  localparam logic [11:0] WAKE_FAST_CNT   = 12'h020;  // 32
  localparam logic [8:0]  TMR_WAKE_CNT    = 9'h100;   // 256 cycles to bit 8
  // slow oscillator modelled as enable: 62 kHz from 250 MHz
  localparam int CLK_HZ  = 250_000_000;
  localparam int SLOW_HZ = 62_000;
  localparam logic [11:0] SLOW_DIV = 12'(CLK_HZ / SLOW_HZ);
  // reset causes
  localparam logic [1:0] RC_POWER = 2'h0;
  localparam logic [1:0] RC_LVR   = 2'h1;
  localparam logic [1:0] RC_PIN   = 2'h2;
  localparam logic [1:0] RC_WDT   = 2'h3;
  typedef enum logic [1:0] {
    LPW_RUN,
    LPW_LIGHT,
    LPW_DEEP,
    LPW_WAKE
  } lpw_mode_t;
endpackage

// ===== logic/lpw_wake_cnt.sv
// wake delay counter, advanced on slow oscillator enable pulses
// assumes start is a one-cycle pulse and tick a one-cycle enable
module lpw_wake_cnt (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        start_i,
  input  wire logic        tick_i,
  input  wire logic [11:0] limit_i,
  output logic             done_o
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        run;
    logic        done;
  } lpw_cnt_t;
  lpw_cnt_t s_q;
  lpw_cnt_t s_d;

  // count slow periods until limit, then pulse done
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.cnt = 12'h000;
      s_d.run = 1'b1;
    end else if (s_q.run && tick_i) begin
      s_d.cnt = s_q.cnt + 12'h001;
      if (s_q.cnt + 12'h001 == limit_i) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign done_o = s_q.done;
endmodule

// ===== logic/lpw_top.sv
// power mode and wake-up sequencer with wishbone register slave
// assumes the core gives one-cycle sleep pulses and pins are synchronous
// Contract
// - three modes: run, light sleep by one op, deep sleep by another
// - light sleep gates only the system clock, oscillators keep state
// - program memory powered off in both sleep modes
// - timers stop in light sleep if on system clock or dead oscillator
// - light sleep ends on enabled input pin toggle or timer event
// - timer on slow osc from zero at bit 8 wakes after 256 periods
// - deep sleep stops every oscillator at once
// - deep sleep keeps data memory and registers unchanged
// - deep sleep wakes only on pin toggle; timers only in light sleep
// - pin wake resumes at next instruction, no restart
// - pin wakes only when wake-enabled and configured as input
// - normal wake resumes 2048 slow periods after the event
// - fast wake resumes 32 slow periods after the event
// - any reset returns registers to defaults and restarts execution
// - data memory kept across pin reset and watchdog reset
// - clock mode bit 1 enables watchdog; slow osc off disables it too
//
// Local design decisions: the address map and register access over Wishbone.
module lpw_top #(
  // core cycles per slow oscillator period; a bench may shorten it
  parameter logic [11:0] SLOW_DIV = lpw_pkg::SLOW_DIV
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        light_sleep_req_i,
  input  wire logic        deep_sleep_req_i,
  input  wire logic [7:0]  pin_in_i,
  input  wire logic [7:0]  pin_direction_bit_i,
  input  wire logic        t16_evt_i,
  input  wire logic        pwm_evt_i,
  input  wire logic        t16_on_sysclk_i,
  input  wire logic        pwm_on_sysclk_i,
  input  wire logic        t16_on_fast_i,
  input  wire logic        pwm_on_fast_i,
  input  wire logic [1:0]  reset_cause_i,
  output logic             sys_clk_en_o,
  output logic             fast_internal_osc_en_o,
  output logic             slow_internal_osc_en_o,
  output logic             otp_power_o,
  output logic             t16_run_o,
  output logic             pwm_run_o,
  output logic             watchdog_timer_en_o,
  output logic             ram_keep_o,
  output logic             resume_o
);
  typedef struct packed {
    lpw_pkg::lpw_mode_t mode;
    logic        deep;
    logic [7:0]  clkmd;
    logic [7:0]  wakeen;
    logic [7:0]  aux;
    logic [7:0]  pin_prev;
    logic [11:0] div;
    logic        tick;
    logic        start;
    logic        ack;
    logic [31:0] rdat;
    logic        ram_keep;
    logic        resume;
    logic        sys_en;
    logic        fast_en;
    logic        slow_en;
    logic        otp;
    logic        t16_run;
    logic        pwm_run;
    logic        wdt_en;
  } lpw_state_t;

  lpw_state_t s_q;
  lpw_state_t s_d;
  logic       cnt_done;
  logic [7:0] pin_wake;
  logic       pin_evt;
  logic       tmr_evt;
  logic       wb_req;
  logic [11:0] wake_limit;

  // pin wake: enabled, input, toggled
  assign pin_wake = (pin_in_i ^ s_q.pin_prev) & s_q.wakeen & pin_direction_bit_i;
  assign pin_evt  = |pin_wake;
  // timer events only count while light sleeping
  assign tmr_evt  = (s_q.mode == lpw_pkg::LPW_LIGHT) && (t16_evt_i || pwm_evt_i);
  assign wb_req   = wb_cyc_i && wb_stb_i && !s_q.ack;
  // fast or normal delay
  assign wake_limit = s_q.aux[lpw_pkg::AUX_FAST_WAKE] ? lpw_pkg::WAKE_FAST_CNT
                                                      : lpw_pkg::WAKE_NORMAL_CNT;

  lpw_wake_cnt u_cnt (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .start_i    (s_q.start),
    .tick_i     (s_q.tick),
    .limit_i    (wake_limit),
    .done_o     (cnt_done)
  );

  // mode sequencing, register slave and output levels
  always_comb begin
    s_d = s_q;
    s_d.start    = 1'b0;
    s_d.resume   = 1'b0;
    s_d.ack      = 1'b0;
    s_d.pin_prev = pin_in_i;
    // ram kept for pin and watchdog resets, caught after release
    s_d.ram_keep = (reset_cause_i == lpw_pkg::RC_PIN)
                   || (reset_cause_i == lpw_pkg::RC_WDT);
    // slow oscillator period as a divider enable
    s_d.tick = 1'b0;
    if (s_q.div == SLOW_DIV - 12'h001) begin
      s_d.div  = 12'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 12'h001;
    end
    // registers: writes only while running, contents frozen in sleep
    if (wb_req) begin
      s_d.ack = 1'b1;
      if (wb_we_i && wb_sel_i[0] && s_q.mode == lpw_pkg::LPW_RUN) begin
        case (wb_adr_i)
          lpw_pkg::ADDR_CLKMD:  s_d.clkmd  = wb_dat_i[7:0];
          lpw_pkg::ADDR_WAKEEN: s_d.wakeen = wb_dat_i[7:0];
          lpw_pkg::ADDR_AUX:    s_d.aux    = wb_dat_i[7:0];
          default: ;
        endcase
      end
      case (wb_adr_i)
        lpw_pkg::ADDR_CLKMD:  s_d.rdat = {24'h000000, s_q.clkmd};
        lpw_pkg::ADDR_WAKEEN: s_d.rdat = {24'h000000, s_q.wakeen};
        lpw_pkg::ADDR_AUX:    s_d.rdat = {24'h000000, s_q.aux};
        lpw_pkg::ADDR_STAT:   s_d.rdat = {28'h0000000, s_q.ram_keep, s_q.deep, s_q.mode};
        default:              s_d.rdat = 32'h00000000;
      endcase
    end
    // mode machine
    case (s_q.mode)
      lpw_pkg::LPW_RUN: begin
        if (deep_sleep_req_i) begin
          s_d.mode = lpw_pkg::LPW_DEEP;
          s_d.deep = 1'b1;
        end else if (light_sleep_req_i) begin
          s_d.mode = lpw_pkg::LPW_LIGHT;
          s_d.deep = 1'b0;
        end
      end
      lpw_pkg::LPW_LIGHT: begin
        if (pin_evt || tmr_evt) begin
          s_d.mode  = lpw_pkg::LPW_WAKE;
          s_d.start = 1'b1;
        end
      end
      lpw_pkg::LPW_DEEP: begin
        if (pin_evt) begin
          s_d.mode  = lpw_pkg::LPW_WAKE;
          s_d.start = 1'b1;
        end
      end
      lpw_pkg::LPW_WAKE: begin
        if (cnt_done) begin
          s_d.mode   = lpw_pkg::LPW_RUN;
          s_d.resume = 1'b1;  // continue at next instruction
        end
      end
      default: s_d.mode = lpw_pkg::LPW_RUN;
    endcase
    // output levels from next mode
    s_d.sys_en  = (s_d.mode == lpw_pkg::LPW_RUN);
    s_d.otp     = (s_d.mode == lpw_pkg::LPW_RUN);
    // oscillators off in deep sleep; slow restarted for the wake count, fast held off until run
    s_d.fast_en = s_q.clkmd[lpw_pkg::CLK_FAST_EN] && (s_d.mode != lpw_pkg::LPW_DEEP)
                  && !(s_d.mode == lpw_pkg::LPW_WAKE && s_q.deep);
    s_d.slow_en = (s_q.clkmd[lpw_pkg::CLK_SLOW_EN] && s_d.mode != lpw_pkg::LPW_DEEP)
                  || s_d.mode == lpw_pkg::LPW_WAKE;
    // timers in light sleep
    s_d.t16_run = s_d.sys_en || (s_d.mode == lpw_pkg::LPW_LIGHT && !t16_on_sysclk_i
                  && (t16_on_fast_i ? s_d.fast_en : s_d.slow_en));
    s_d.pwm_run = s_d.sys_en || (s_d.mode == lpw_pkg::LPW_LIGHT && !pwm_on_sysclk_i
                  && (pwm_on_fast_i ? s_d.fast_en : s_d.slow_en));
    // watchdog enable and slow osc dependency
    s_d.wdt_en  = s_q.clkmd[lpw_pkg::CLK_WDT_EN] && s_q.clkmd[lpw_pkg::CLK_SLOW_EN]
                  && s_d.slow_en;
  end

  // register the state; any reset restores defaults
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q         <= '0;
      s_q.mode    <= lpw_pkg::LPW_RUN;
      s_q.clkmd   <= lpw_pkg::CLKMD_RST;
      s_q.wakeen  <= lpw_pkg::WAKEEN_RST;
      s_q.aux     <= lpw_pkg::AUX_RST;
      s_q.sys_en  <= 1'b1;
      s_q.otp     <= 1'b1;
      s_q.fast_en <= 1'b1;
      s_q.slow_en <= 1'b1;
      s_q.t16_run <= 1'b1;
      s_q.pwm_run <= 1'b1;
      s_q.wdt_en  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o               = s_q.rdat;
  assign wb_ack_o               = s_q.ack;
  assign sys_clk_en_o           = s_q.sys_en;
  assign fast_internal_osc_en_o = s_q.fast_en;
  assign slow_internal_osc_en_o = s_q.slow_en;
  assign otp_power_o            = s_q.otp;
  assign t16_run_o              = s_q.t16_run;
  assign pwm_run_o              = s_q.pwm_run;
  assign watchdog_timer_en_o    = s_q.wdt_en;
  assign ram_keep_o             = s_q.ram_keep;
  assign resume_o               = s_q.resume;

  // checks
  a_sleep_gates_clk: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.mode != lpw_pkg::LPW_RUN) |-> !sys_clk_en_o && !otp_power_o)
    else $error("system clock or otp on while asleep");
  a_deep_osc_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.mode == lpw_pkg::LPW_RUN && deep_sleep_req_i) |=> !fast_internal_osc_en_o
    && !slow_internal_osc_en_o)
    else $error("oscillator still on in deep sleep");
  a_deep_no_timer: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.mode == lpw_pkg::LPW_DEEP && !pin_evt) |=> s_q.mode == lpw_pkg::LPW_DEEP)
    else $error("deep sleep left without pin toggle");
  a_wdt_needs_slow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !s_q.clkmd[lpw_pkg::CLK_SLOW_EN] |=> !watchdog_timer_en_o)
    else $error("watchdog on with slow oscillator off");
  a_regs_frozen: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.mode == lpw_pkg::LPW_DEEP) |=> $stable(s_q.wakeen) && $stable(s_q.aux))
    else $error("register changed in deep sleep");
  a_pin_gated: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.mode == lpw_pkg::LPW_DEEP && s_q.wakeen == 8'h00) |=> !s_q.start)
    else $error("wake from disabled pin");
  a_wake_resume: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    resume_o |-> $past(s_q.mode) == lpw_pkg::LPW_WAKE && sys_clk_en_o)
    else $error("resume without wake sequence");
  a_fast_wait: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (s_q.start && s_q.aux[lpw_pkg::AUX_FAST_WAKE]) |-> ##[1:8] (s_q.mode == lpw_pkg::LPW_WAKE)
    ##1 !resume_o)
    else $error("fast wake resumed too early");
  c_light: cover property (@(posedge core_clk_i) s_q.mode == lpw_pkg::LPW_LIGHT);
  c_deep: cover property (@(posedge core_clk_i) s_q.mode == lpw_pkg::LPW_DEEP);
  c_resume: cover property (@(posedge core_clk_i) resume_o);
endmodule

// ===== bench/lpw_far_model.sv
// far side model: core sleep ops, port pins and the 16-bit timer event
// assumes the bench calls its tasks; every change follows a rising clock edge
module lpw_far_model (
  input  wire logic core_clk_i,
  output logic       light_req_o,
  output logic       deep_req_o,
  output logic       t16_evt_o,
  output logic [7:0] pin_o,
  output logic [7:0] dir_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels; pins 0 and 2 set as digital inputs by software
  initial begin
    light_req_o = 1'b0;
    deep_req_o  = 1'b0;
    t16_evt_o   = 1'b0;
    pin_o       = 8'h00;
    dir_o       = 8'h05;
  end
  // one-cycle pulse: 0 light sleep op, 1 deep sleep op, 2 timer event
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    light_req_o <= (k == 0);
    deep_req_o  <= (k == 1);
    t16_evt_o   <= (k == 2);
    @(posedge core_clk_i);
    light_req_o <= 1'b0;
    deep_req_o  <= 1'b0;
    t16_evt_o   <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // toggle one port pin
  task automatic toggle(input int b);
    @(posedge core_clk_i);
    pin_o[b] <= ~pin_o[b];
  endtask
endmodule

// ===== bench/low_power_wakeup_control_tb.sv
// self-checking bench for the power mode and wake-up sequencer
// assumes lpw_pkg, lpw_top and the far side model are compiled first
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module low_power_wakeup_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [3:0]  adr      = 4'h0;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic [1:0]  cause    = 2'h0;
  logic [31:0] rdat, dat_o;
  logic [7:0]  pins, dirs;
  logic        light, deep, tev, ack, sys_en, fast_en, slow_en, otp;
  logic        t16_run, pwm_run, wdt_en, keep, resume;
  logic        pwm_ev = 1'b0;
  logic        t_sys  = 1'b0;
  logic        p_sys  = 1'b1;
  logic        p_fast = 1'b0;
  // shortened slow period keeps the whole run in budget
  localparam logic [11:0] TB_DIV = 12'h010;
  int          n_fail = 0;
  int          check_count = 0;
  int          n;
  int          sd = int'(TB_DIV);
  // 250 MHz core clock
  always #2 core_clk = ~core_clk;
  lpw_top #(
    .SLOW_DIV (TB_DIV)
  ) DUT (
    .core_clk_i             (core_clk),
    .arst_n_i               (arst_n),
    .wb_cyc_i               (cyc),
    .wb_stb_i               (stb),
    .wb_we_i                (we),
    .wb_adr_i               (adr),
    .wb_sel_i               (sel),
    .wb_dat_i               (wdat),
    .wb_dat_o               (dat_o),
    .wb_ack_o               (ack),
    .light_sleep_req_i      (light),
    .deep_sleep_req_i       (deep),
    .pin_in_i               (pins),
    .pin_direction_bit_i    (dirs),
    .t16_evt_i              (tev),
    .pwm_evt_i              (pwm_ev),
    .t16_on_sysclk_i        (t_sys),
    .pwm_on_sysclk_i        (p_sys),
    .t16_on_fast_i          (1'b0),
    .pwm_on_fast_i          (p_fast),
    .reset_cause_i          (cause),
    .sys_clk_en_o           (sys_en),
    .fast_internal_osc_en_o (fast_en),
    .slow_internal_osc_en_o (slow_en),
    .otp_power_o            (otp),
    .t16_run_o              (t16_run),
    .pwm_run_o              (pwm_run),
    .watchdog_timer_en_o    (wdt_en),
    .ram_keep_o             (keep),
    .resume_o               (resume)
  );
  lpw_far_model far (
    .core_clk_i  (core_clk),
    .light_req_o (light),
    .deep_req_o  (deep),
    .t16_evt_o   (tev),
    .pin_o       (pins),
    .dir_o       (dirs)
  );
  // classic wishbone single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h1;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdat = dat_o;
    if (ack !== 1'b1) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    repeat (2) @(posedge core_clk);
  endtask
  // read and compare
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // count cycles until the resume pulse, bounded
  task automatic wait_res(input int lim);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (resume !== 1'b1 && n < lim);
  endtask
  // reset held for 10 cycles with a given cause
  task automatic hard_rst(input logic [1:0] c);
    @(posedge core_clk);
    cause  <= c;
    arst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard: two 32-period wakes, one 2048-period wake, resets and bus traffic
  initial begin
    #(60_000 * 4);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    hard_rst(2'h0);
    `CHK({sys_en, otp, fast_en, slow_en, wdt_en, keep}, 6'b111110)
    rd(lpw_pkg::ADDR_CLKMD, 32'hf6);
    rd(lpw_pkg::ADDR_STAT, 32'h0);
    bus(1'b1, 4'h2, 32'hff);
    rd(4'h2, 32'h0);
    bus(1'b1, lpw_pkg::ADDR_CLKMD, 32'hf2);
    `CHK({slow_en, wdt_en}, 2'b00)
    bus(1'b1, lpw_pkg::ADDR_CLKMD, 32'hf4); // watchdog off first
    `CHK({slow_en, wdt_en}, 2'b10)
    bus(1'b1, lpw_pkg::ADDR_WAKEEN, 32'h03); // pins 0 and 1 wake enabled
    bus(1'b1, lpw_pkg::ADDR_AUX, 32'h01);
    // light sleep, bad pins ignored, timer event wakes
    far.pulse(0);
    `CHK({sys_en, otp, fast_en, slow_en}, 4'b0011)
    `CHK({t16_run, pwm_run}, 2'b10)
    // sixteen_bit_timer on system clock stops, pwm timer on fast osc runs
    t_sys  <= 1'b1;
    p_sys  <= 1'b0;
    p_fast <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK({t16_run, pwm_run}, 2'b01)
    t_sys  <= 1'b0;
    p_sys  <= 1'b1;
    p_fast <= 1'b0;
    bus(1'b1, lpw_pkg::ADDR_AUX, 32'h00);
    far.toggle(1);
    far.toggle(2);
    rd(lpw_pkg::ADDR_STAT, 32'h1);
    far.pulse(2);
    wait_res(40 * sd);
    `CHK(n >= 31 * sd && n <= 33 * sd, 1'b1)
    repeat (2) @(posedge core_clk);
    `CHK({sys_en, otp}, 2'b11)
    rd(lpw_pkg::ADDR_AUX, 32'h1);
    // deep sleep, timer ignored, pin wakes
    bus(1'b1, lpw_pkg::ADDR_CLKMD, 32'hf6); // watchdog back on
    far.pulse(1);
    `CHK({sys_en, otp, fast_en, slow_en, wdt_en}, 5'b0)
    far.pulse(2);
    @(posedge core_clk);
    pwm_ev <= 1'b1;
    @(posedge core_clk);
    pwm_ev <= 1'b0;
    bus(1'b0, lpw_pkg::ADDR_STAT, 32'h0);
    `CHK(rdat[1:0], 2'h2)
    far.toggle(0);
    wait_res(40 * sd);
    `CHK(n >= 31 * sd && n <= 33 * sd, 1'b1)
    repeat (2) @(posedge core_clk);
    `CHK({sys_en, fast_en, slow_en, wdt_en, keep}, 5'b11110)
    rd(lpw_pkg::ADDR_WAKEEN, 32'h3);
    rd(lpw_pkg::ADDR_STAT, 32'h4);
    // normal wake outlasts the fast count, then reset mid-count
    bus(1'b1, lpw_pkg::ADDR_AUX, 32'h0);
    far.pulse(1);
    far.toggle(0);
    wait_res(2100 * sd);
    `CHK(n >= 2047 * sd && n <= 2049 * sd, 1'b1)
    // deep sleep again, the reset below lands mid-count
    far.pulse(1);
    far.toggle(0);
    repeat (5 * sd) @(posedge core_clk);
    for (int c = 0; c < 4; c++) begin
      hard_rst(2'(c));
      `CHK({sys_en, keep}, {1'b1, c >= 2})
      rd(lpw_pkg::ADDR_AUX, 32'h0);
    end
    finish_test();
  end
endmodule
